/* lpu_pkg.sv */
package lpu_pkg;
    // Register byte offsets
    localparam logic [7:0] LPU_OFF_DATA   = 8'h00;
    localparam logic [7:0] LPU_OFF_CTRL   = 8'h04;
    localparam logic [7:0] LPU_OFF_ADDR   = 8'h08;
    localparam logic [7:0] LPU_OFF_MASK   = 8'h0c;
    localparam logic [7:0] LPU_OFF_STAT   = 8'h10;
    localparam logic [7:0] LPU_OFF_CLR    = 8'h14;
    localparam logic [7:0] LPU_OFF_BAUD   = 8'h18;
    // Control field positions
    localparam int LPU_B_RXIE  = 0;
    localparam int LPU_B_TXIE  = 1;
    localparam int LPU_B_RX9   = 2;
    localparam int LPU_B_TX9   = 3;
    localparam int LPU_B_REN   = 4;
    localparam int LPU_B_MPF   = 5;
    localparam int LPU_B_MODE0 = 6;
    localparam int LPU_B_DBL   = 9;
    localparam int LPU_B_EN    = 16;
    // Flag positions, baud select bit and shared constants
    localparam int LPU_F_RX    = 0;
    localparam int LPU_F_TX    = 1;
    localparam int LPU_F_FERR  = 2;
    localparam int LPU_B_ISEL  = 16;
    localparam logic [31:0] LPU_CTRL_RST = 32'h0000_e000;
    localparam logic [1:0]  LPU_RESP_OK  = 2'b00;
    localparam logic [1:0]  LPU_RESP_ERR = 2'b10;
    localparam logic [4:0]  LPU_OVS      = 5'h1f;
    localparam logic [3:0]  LPU_MID      = 4'h7;

    typedef enum logic [1:0] {LPU_SHIFT, LPU_MODE1, LPU_MODE2, LPU_MODE3} lpu_mode_t;
    typedef enum {LPU_IDLE, LPU_START, LPU_DATA, LPU_NINTH, LPU_STOP} lpu_st_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic       awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       wvalid;
        logic       bready;
        logic [7:0] araddr;
        logic       arvalid;
        logic       rready;
    } lpu_axi_req_t;

    typedef struct packed {
        logic       awready;
        logic       wready;
        logic [1:0] bresp;
        logic       bvalid;
        logic       arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic       rvalid;
    } lpu_axi_rsp_t;
endpackage : lpu_pkg

/* lpu_uart.sv */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
// Functional notes
// RULE_01: In 9-bit modes with filtering, frames with ninth bit 1 stored, flag raised.
// RULE_02: Under address monitoring, frames with ninth bit 0 are discarded.
// RULE_03: Filtering off: every frame stored and flagged; ninth bit is a check bit.
// RULE_04: Receive enable bit 4: 0 transmit only, 1 receive (and transmit); in shift mode the code blocks transmit while bit 4 is 1.
// RULE_05: Receive interrupt requested only when bit 0 enable and receive flag set.
// RULE_06: Own address register, bits 7:0, read/write, used in address compare.
// RULE_07: Address mask register, bits 7:0, read/write, selects compared bits.
// RULE_08: Frame error flag bit 2 set on missing stop bit; software clears.
// RULE_09: Transmit done flag bit 1 set at frame end; held until cleared.
// RULE_10: Receive done flag bit 0 set at reception end; held until cleared.
// RULE_11: Clear register bits 2..0 write one clears flags; zero ignored; write only.
// RULE_12: Baud select bit 16: 0 external timer tick, 1 internal divisor.
// RULE_13: Internal rate is (double+1) times serial clock over 32 times (divisor+1).
// RULE_14: Mask zero bits are don't care; given address is address AND mask.
// RULE_15: Broadcast address, address OR mask, is also accepted.
// RULE_16: Frame error flag stays set through later good frames until cleared.
// RULE_17: In 8-bit mode filtering uses the stop bit instead of the ninth bit.
// RULE_18: Transmit interrupt needs bit 1 enable; all requests form one line.
module lpu_uart
    import lpu_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_clk_en,
    // Register bus
    input  wire lpu_pkg::lpu_axi_req_t i_axi,
    output      lpu_pkg::lpu_axi_rsp_t o_axi,
    // Serial line and external baud tick
    input  wire logic                  i_rxd,
    input  wire logic                  i_lptim_tick,
    output      logic                  o_txd,
    // Interrupt
    output      logic                  o_irq
);
    import lpu_pkg::*;

    logic [31:0] ctrl_r;
    logic [7:0]  own_addr_r;
    logic [7:0]  mask_r;
    logic [16:0] baud_r;
    logic [2:0]  flags_r;
    logic [7:0]  rx_buf_r;
    lpu_axi_rsp_t axi_r;
    logic        irq_r;

    wire lpu_mode_t mode   = lpu_mode_t'(ctrl_r[LPU_B_MODE0 +: 2]);
    wire logic      nine   = mode == LPU_MODE2 || mode == LPU_MODE3;
    wire logic      en     = ctrl_r[LPU_B_EN];
    // RULE_04 receive enable
    wire logic      rx_on  = en && ctrl_r[LPU_B_REN];

    // AXI write: address and data taken in either order
    logic        aw_have_r;
    logic        w_have_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    wire logic   wr_go = aw_have_r && w_have_r && !axi_r.bvalid;
    wire logic   rd_go = i_axi.arvalid && axi_r.arready;
    logic [31:0] wmask;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wmask[i*8 +: 8] = {8{w_strb_r[i]}};
        end
    end
    wire logic [31:0] wval = w_data_r & wmask;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            axi_r     <= '0;
        end
        else if (i_clk_en)
        begin
            axi_r.awready <= !aw_have_r && !(i_axi.awvalid && axi_r.awready);
            axi_r.wready  <= !w_have_r && !(i_axi.wvalid && axi_r.wready);
            if (i_axi.awvalid && axi_r.awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= i_axi.awaddr;
            end
            if (i_axi.wvalid && axi_r.wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= i_axi.wdata;
                w_strb_r <= i_axi.wstrb;
            end
            if (wr_go)
            begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                axi_r.bvalid <= 1'b1;
                axi_r.bresp  <= (aw_addr_r[1:0] == 2'b00 && aw_addr_r <= LPU_OFF_BAUD)
                                ? LPU_RESP_OK : LPU_RESP_ERR;
            end
            else if (axi_r.bvalid && i_axi.bready)
            begin
                axi_r.bvalid <= 1'b0;
            end
            axi_r.arready <= !axi_r.rvalid && !rd_go;
            if (rd_go)
            begin
                axi_r.rvalid <= 1'b1;
                axi_r.rresp  <= LPU_RESP_OK;
                case (i_axi.araddr)
                    LPU_OFF_DATA: axi_r.rdata <= {24'h00_0000, rx_buf_r};
                    LPU_OFF_CTRL: axi_r.rdata <= ctrl_r;
                    LPU_OFF_ADDR: axi_r.rdata <= {24'h00_0000, own_addr_r};
                    LPU_OFF_MASK: axi_r.rdata <= {24'h00_0000, mask_r};
                    LPU_OFF_STAT: axi_r.rdata <= {29'h0000_0000, flags_r};
                    LPU_OFF_CLR:  axi_r.rdata <= 32'h0000_0000;
                    LPU_OFF_BAUD: axi_r.rdata <= {15'h0000, baud_r};
                    default:
                    begin
                        axi_r.rdata <= 32'h0000_0000;
                        axi_r.rresp <= LPU_RESP_ERR;
                    end
                endcase
            end
            else if (axi_r.rvalid && i_axi.rready)
            begin
                axi_r.rvalid <= 1'b0;
            end
        end
    end
    assign o_axi = axi_r;

    // Configuration registers
    wire logic wr_ctrl = wr_go && aw_addr_r == LPU_OFF_CTRL;
    wire logic wr_data = wr_go && aw_addr_r == LPU_OFF_DATA;
    wire logic wr_clr  = wr_go && aw_addr_r == LPU_OFF_CLR;
    logic      rx_set_ctrl9;
    logic      rx_ninth_val;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_r     <= LPU_CTRL_RST;
            own_addr_r <= 8'h00;
            mask_r     <= 8'h00;
            baud_r     <= 17'h0_0000;
        end
        else if (i_clk_en)
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= {15'h0000, wval[16:0]};
            end
            else if (rx_set_ctrl9)
            begin
                ctrl_r[LPU_B_RX9] <= rx_ninth_val;
            end
            // RULE_06 own address
            if (wr_go && aw_addr_r == LPU_OFF_ADDR)
            begin
                own_addr_r <= wval[7:0];
            end
            // RULE_07 address mask
            if (wr_go && aw_addr_r == LPU_OFF_MASK)
            begin
                mask_r <= wval[7:0];
            end
            if (wr_go && aw_addr_r == LPU_OFF_BAUD)
            begin
                baud_r <= wval[16:0];
            end
        end
    end

    // RULE_12 RULE_13 oversample tick: 32 ticks per bit, halved when doubled
    logic [15:0] div_cnt_r;
    logic        os_tick;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_cnt_r <= 16'h0000;
        end
        else if (i_clk_en)
        begin
            div_cnt_r <= (div_cnt_r >= baud_r[15:0]) ? 16'h0000 : div_cnt_r + 16'h0001;
        end
    end
    assign os_tick = baud_r[LPU_B_ISEL] ? (div_cnt_r >= baud_r[15:0]) : i_lptim_tick;
    wire logic [4:0] os_step = ctrl_r[LPU_B_DBL] ? 5'h02 : 5'h01;

    // Receiver
    lpu_st_t     rx_st_r;
    logic [4:0]  rx_os_r;
    logic [2:0]  rx_bit_r;
    logic [7:0]  rx_sh_r;
    logic        rx_9_r;
    logic        rx_done;
    logic        rx_ferr;
    logic        rx_store;
    wire logic   samp = (rx_os_r == {1'b0, LPU_MID}) || (rx_os_r == {1'b0, LPU_MID} + 5'h01
                        && ctrl_r[LPU_B_DBL]);
    wire logic   bit_end = {1'b0, rx_os_r} + {1'b0, os_step} > {1'b0, LPU_OVS};
    wire logic [7:0] given = own_addr_r & mask_r;
    wire logic [7:0] bcast = own_addr_r | mask_r;
    // RULE_14 RULE_15 masked compare against given and broadcast addresses
    wire logic   addr_hit = ((rx_sh_r & mask_r) == given)
                         || ((rx_sh_r & mask_r) == (bcast & mask_r));
    wire logic   mpf = ctrl_r[LPU_B_MPF];

    always_comb
    begin
        rx_store     = 1'b0;
        rx_ferr      = 1'b0;
        rx_set_ctrl9 = 1'b0;
        rx_ninth_val = rx_9_r;
        if (rx_done)
        begin
            rx_ferr = !i_rxd && mode != LPU_SHIFT;
            if (!mpf || mode == LPU_SHIFT)
            begin
                // RULE_03 unfiltered store
                rx_store = 1'b1;
            end
            else if (nine)
            begin
                // RULE_01 RULE_02 ninth-bit screen then address match
                rx_store = rx_9_r && addr_hit;
            end
            else
            begin
                // RULE_17 stop bit stands in for ninth bit
                rx_store = i_rxd && addr_hit;
            end
            rx_set_ctrl9 = rx_store && nine;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_st_r  <= LPU_IDLE;
            rx_os_r  <= 5'h00;
            rx_bit_r <= 3'h0;
            rx_sh_r  <= 8'h00;
            rx_9_r   <= 1'b0;
            rx_done  <= 1'b0;
            rx_buf_r <= 8'h00;
        end
        else if (i_clk_en)
        begin
            rx_done <= 1'b0;
            if (rx_store)
            begin
                rx_buf_r <= rx_sh_r;
            end
            if (!rx_on)
            begin
                rx_st_r <= LPU_IDLE;
            end
            else if (os_tick)
            begin
                rx_os_r <= bit_end ? 5'h00 : rx_os_r + os_step;
                case (rx_st_r)
                    LPU_IDLE:
                    begin
                        rx_os_r <= 5'h00;
                        if (!i_rxd)
                        begin
                            rx_st_r <= LPU_START;
                        end
                    end
                    LPU_START:
                    begin
                        if (samp && i_rxd)
                        begin
                            rx_st_r <= LPU_IDLE;
                        end
                        else if (bit_end)
                        begin
                            rx_st_r  <= LPU_DATA;
                            rx_bit_r <= 3'h0;
                        end
                    end
                    LPU_DATA:
                    begin
                        if (samp)
                        begin
                            rx_sh_r <= {i_rxd, rx_sh_r[7:1]};
                        end
                        if (bit_end)
                        begin
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == 3'h7)
                            begin
                                rx_st_r <= nine ? LPU_NINTH : LPU_STOP;
                            end
                        end
                    end
                    LPU_NINTH:
                    begin
                        if (samp)
                        begin
                            rx_9_r <= i_rxd;
                        end
                        if (bit_end)
                        begin
                            rx_st_r <= LPU_STOP;
                        end
                    end
                    LPU_STOP:
                    begin
                        if (samp)
                        begin
                            rx_done <= 1'b1;
                            rx_st_r <= LPU_IDLE;
                        end
                    end
                    default: rx_st_r <= LPU_IDLE;
                endcase
            end
        end
    end

    // Transmitter: start, data, optional ninth, stop
    logic [10:0] tx_sh_r;
    logic [3:0]  tx_left_r;
    logic [4:0]  tx_os_r;
    logic        tx_done;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_sh_r   <= 11'h7ff;
            tx_left_r <= 4'h0;
            tx_os_r   <= 5'h00;
            tx_done   <= 1'b0;
            o_txd     <= 1'b1;
        end
        else if (i_clk_en)
        begin
            tx_done <= 1'b0;
            // RULE_04 transmit blocked in shift mode when receiving
            if (wr_data && tx_left_r == 4'h0 && en
                && !(mode == LPU_SHIFT && ctrl_r[LPU_B_REN]))
            begin
                tx_sh_r   <= nine ? {1'b1, ctrl_r[LPU_B_TX9], wval[7:0], 1'b0}
                                  : {2'b11, wval[7:0], 1'b0};
                tx_left_r <= nine ? 4'hb : 4'ha;
                tx_os_r   <= 5'h00;
            end
            else if (tx_left_r != 4'h0 && os_tick)
            begin
                o_txd <= tx_sh_r[0];
                if ({1'b0, tx_os_r} + {1'b0, os_step} > {1'b0, LPU_OVS})
                begin
                    tx_os_r   <= 5'h00;
                    tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                    tx_left_r <= tx_left_r - 4'h1;
                    tx_done   <= tx_left_r == 4'h1;
                end
                else
                begin
                    tx_os_r <= tx_os_r + os_step;
                end
            end
            else if (tx_left_r == 4'h0)
            begin
                o_txd <= 1'b1;
            end
        end
    end

    // Sticky flags: set wins over clear
    logic [2:0] set_v;
    assign set_v = {rx_done && rx_ferr, tx_done, rx_store};
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            flags_r <= 3'b000;
            irq_r   <= 1'b0;
        end
        else if (i_clk_en)
        begin
            // RULE_08 RULE_09 RULE_10 RULE_11 RULE_16 set and write-one clear
            flags_r <= (flags_r & ~({3{wr_clr}} & wval[2:0])) | set_v;
            // RULE_05 RULE_18 combined request line
            irq_r   <= (flags_r[LPU_F_RX] && ctrl_r[LPU_B_RXIE])
                    || (flags_r[LPU_F_TX] && ctrl_r[LPU_B_TXIE]);
        end
    end
    assign o_irq = irq_r;

    a_ferr_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_16
        i_clk_en && flags_r[LPU_F_FERR] && !(wr_clr && wval[LPU_F_FERR])
        |=> flags_r[LPU_F_FERR])
        else $error("frame error flag dropped");
    a_rx_store: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_10
        i_clk_en && rx_store |=> flags_r[LPU_F_RX])
        else $error("receive flag not set");
    a_tx_done: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_09
        i_clk_en && tx_done |=> flags_r[LPU_F_TX])
        else $error("transmit flag not set");
    a_nine_screen: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_02
        rx_done && mpf && nine && !rx_9_r |-> !rx_store)
        else $error("data frame passed monitor");
    a_unfiltered: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_03
        rx_done && !mpf |-> rx_store)
        else $error("unfiltered frame dropped");
    a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_05
        i_clk_en && !ctrl_r[LPU_B_RXIE] && !ctrl_r[LPU_B_TXIE] |=> !o_irq)
        else $error("irq without enable");
    a_clear_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_11
        i_clk_en && wr_clr && wval[LPU_F_TX] && !tx_done |=> !flags_r[LPU_F_TX])
        else $error("clear ignored");
    a_rx_off: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_04
        !rx_on |=> rx_st_r == LPU_IDLE || !$past(i_clk_en))
        else $error("receiver ran while off");
    c_rx: cover property (@(posedge i_sys_clk) rx_store);
    c_tx: cover property (@(posedge i_sys_clk) tx_done);
    c_ferr: cover property (@(posedge i_sys_clk) rx_done && rx_ferr);
endmodule : lpu_uart

/* lpu_remote.sv */
`timescale 1ns/100ps
module lpu_remote (
    // Clock
    input  wire logic i_sys_clk,
    // Serial line
    input  wire logic i_txd,
    output      logic o_rxd
);
    int         per;
    int         got_count;
    logic [7:0] got_byte;
    initial
    begin
        per       = 64;
        got_count = 0;
        got_byte  = 8'h00;
        o_rxd     = 1'b1;
    end
    // Sends start, data LSB first, optional ninth bit, then stop
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        logic [10:0] f;
        int          nb;
        nb = nine ? 11 : 10;
        f  = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        for (int i = 0; i < nb; i++)
        begin
            @(posedge i_sys_clk);
            o_rxd <= f[i];
            repeat (per - 1) @(posedge i_sys_clk);
        end
        @(posedge i_sys_clk);
        o_rxd <= 1'b1;
    endtask : send
    // Samples each of the 8 transmitted data bits in its middle
    always
    begin
        @(negedge i_txd);
        repeat (per / 2) @(posedge i_sys_clk);
        for (int k = 0; k < 8; k++)
        begin
            repeat (per) @(posedge i_sys_clk);
            got_byte[k] = i_txd;
        end
        got_count++;
    end
endmodule : lpu_remote

/* test_lp_uart_rx_addr_flags_baud.sv */
`timescale 1ns/100ps
module test_lp_uart_rx_addr_flags_baud;
    import lpu_pkg::*;
    localparam logic [31:0] F_RCV = 32'h0000_0010;
    localparam logic [31:0] F_MPF = 32'h0000_0020;
    localparam logic [31:0] F_RIE = 32'h0000_0001;
    localparam logic [31:0] F_TIE = 32'h0000_0002;
    localparam logic [31:0] F_DBL = 32'h0000_0200;
    logic         i_sys_clk;
    logic         i_rst;
    logic         tick;
    logic         tick_on;
    logic         rxd;
    logic         txd;
    logic         irq;
    lpu_axi_req_t rq;
    lpu_axi_rsp_t rs;
    int           err_count;
    int           n_compared;
    int           n;
    logic [31:0]  rv;
    logic [1:0]   rr;
    lpu_uart dut_u (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_clk_en     (1'b1),
        .i_axi        (rq),
        .o_axi        (rs),
        .i_rxd        (rxd),
        .i_lptim_tick (tick),
        .o_txd        (txd),
        .o_irq        (irq)
    );
    lpu_remote rem_u (
        .i_sys_clk (i_sys_clk),
        .i_txd     (txd),
        .o_rxd     (rxd)
    );
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // External timer tick every second cycle when on
    always @(posedge i_sys_clk) tick <= tick_on & ~tick;
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_sys_clk);
        rq.awaddr  <= a;
        rq.wdata   <= d;
        rq.wstrb   <= 4'hf;
        rq.awvalid <= 1'b1;
        rq.wvalid  <= 1'b1;
        rq.bready  <= 1'b1;
        do
        begin
            @(posedge i_sys_clk);
            k++;
            if (rs.awready && rq.awvalid) rq.awvalid <= 1'b0;
            if (rs.wready && rq.wvalid) rq.wvalid <= 1'b0;
        end while (!(rs.bvalid && rq.bready) && k < 100);
        rr = rs.bresp;
        rq.bready <= 1'b0;
        if (k >= 100) chk(0, 1, "write hang");
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_sys_clk);
        rq.araddr  <= a;
        rq.arvalid <= 1'b1;
        rq.rready  <= 1'b1;
        do
        begin
            @(posedge i_sys_clk);
            k++;
            if (rs.arready && rq.arvalid) rq.arvalid <= 1'b0;
        end while (!(rs.rvalid && rq.rready) && k < 100);
        d  = rs.rdata;
        rr = rs.rresp;
        rq.rready <= 1'b0;
        if (k >= 100) chk(0, 1, "read hang");
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] d;
        rd(a, d);
        chk(d, e, m);
    endtask : rchk
    function automatic logic [31:0] cw(input logic [1:0] md, input logic [31:0] f);
        return 32'h0001_0000 | {24'h00_0000, md, 6'h00} | f;
    endfunction : cw
    // Configures, sends one frame, compares flags and stored data
    task automatic rxc(input logic [31:0] c, input logic [8:0] d, input logic nine,
                       input logic [2:0] ex);
        wr(LPU_OFF_CTRL, c);
        wr(LPU_OFF_CLR, 32'h0000_0007);
        rem_u.send(d, nine, 1'b1);
        repeat (8) @(posedge i_sys_clk);
        rchk(LPU_OFF_STAT, {29'h0, ex}, "status");
        if (ex[0]) rchk(LPU_OFF_DATA, {24'h00_0000, d[7:0]}, "data");
    endtask : rxc
    initial
    begin
        repeat (50000) @(posedge i_sys_clk);
        err_count++;
        end_sim;
    end
    initial
    begin
        i_rst      = 1'b1;
        rq         = '0;
        tick       = 1'b0;
        tick_on    = 1'b0;
        err_count  = 0;
        n_compared = 0;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        rchk(LPU_OFF_CTRL, LPU_CTRL_RST, "ctrl reset");
        rchk(LPU_OFF_ADDR, 32'h0000_0000, "addr reset");
        rchk(LPU_OFF_MASK, 32'h0000_0000, "mask reset");
        rchk(LPU_OFF_STAT, 32'h0000_0000, "flags reset");
        rchk(LPU_OFF_BAUD, 32'h0000_0000, "baud reset");
        rchk(8'h1c, 32'h0000_0000, "unmapped data");
        chk(rr, LPU_RESP_ERR, "unmapped resp");
        wr(8'h1c, 32'h0000_0000);
        chk(rr, LPU_RESP_ERR, "unmapped write");
        wr(LPU_OFF_ADDR, 32'hffff_ff69);
        chk(rr, LPU_RESP_OK, "write resp");
        rchk(LPU_OFF_ADDR, 32'h0000_0069, "own address");
        wr(LPU_OFF_MASK, 32'hffff_fffb);
        rchk(LPU_OFF_MASK, 32'h0000_00fb, "mask");
        wr(LPU_OFF_CLR, 32'h0000_0007);
        rchk(LPU_OFF_CLR, 32'h0000_0000, "clear reads zero");
        $display("Test registers done");
        wr(LPU_OFF_BAUD, 32'h0001_0001);
        rem_u.per = 64;
        rxc(cw(2'd3, F_RCV | F_MPF), 9'h069, 1'b1, 3'b000);
        rxc(cw(2'd3, F_RCV | F_MPF), 9'h16d, 1'b1, 3'b001);
        rchk(LPU_OFF_CTRL, cw(2'd3, F_RCV | F_MPF) | 32'h0000_0004, "ninth bit");
        rxc(cw(2'd3, F_RCV | F_MPF), 9'h16b, 1'b1, 3'b000);
        rxc(cw(2'd3, F_RCV | F_MPF), 9'h1ff, 1'b1, 3'b001);
        rxc(cw(2'd3, F_RCV), 9'h033, 1'b1, 3'b001);
        rxc(cw(2'd1, F_RCV | F_MPF), 9'h069, 1'b0, 3'b001);
        rxc(cw(2'd1, F_RCV | F_MPF), 9'h06b, 1'b0, 3'b000);
        rxc(cw(2'd2, F_RCV | F_MPF), 9'h06d, 1'b1, 3'b000);
        rxc(cw(2'd0, F_RCV | F_MPF), 9'h06b, 1'b0, 3'b001);
        rxc(cw(2'd1, 32'h0000_0000), 9'h05a, 1'b0, 3'b000);
        rxc(cw(2'd1, F_RCV), 9'h05a, 1'b0, 3'b001);
        $display("Test address filter done");
        chk(irq, 1'b0, "irq masked");
        wr(LPU_OFF_CTRL, cw(2'd1, F_RCV | F_RIE));
        repeat (2) @(posedge i_sys_clk);
        chk(irq, 1'b1, "rx irq");
        wr(LPU_OFF_CLR, 32'h0000_0000);
        rchk(LPU_OFF_STAT, 32'h0000_0001, "zero write");
        wr(LPU_OFF_CLR, 32'h0000_0001);
        repeat (2) @(posedge i_sys_clk);
        chk(irq, 1'b0, "rx irq cleared");
        $display("Test receive interrupt done");
        wr(LPU_OFF_CTRL, cw(2'd1, F_RCV));
        rem_u.send(9'h0a5, 1'b0, 1'b0);
        repeat (8) @(posedge i_sys_clk);
        rd(LPU_OFF_STAT, rv);
        chk(rv & 32'h0000_0004, 32'h0000_0004, "frame error");
        // Low stop bit looks like a new start: let that frame run out
        repeat (800) @(posedge i_sys_clk);
        rem_u.send(9'h0a5, 1'b0, 1'b1);
        repeat (8) @(posedge i_sys_clk);
        rchk(LPU_OFF_STAT, 32'h0000_0005, "error kept");
        wr(LPU_OFF_CLR, 32'h0000_0003);
        rchk(LPU_OFF_STAT, 32'h0000_0004, "error only");
        wr(LPU_OFF_CLR, 32'h0000_0004);
        rchk(LPU_OFF_STAT, 32'h0000_0000, "error cleared");
        $display("Test frame error done");
        wr(LPU_OFF_CTRL, cw(2'd1, F_RCV | F_TIE));
        wr(LPU_OFF_DATA, 32'h0000_00c3);
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge i_sys_clk);
        chk(rem_u.got_byte, 8'hc3, "sent byte");
        chk(rem_u.got_count, 32'h0000_0001, "one frame sent");
        rchk(LPU_OFF_STAT, 32'h0000_0002, "tx flag");
        chk(irq, 1'b1, "tx irq");
        wr(LPU_OFF_CTRL, cw(2'd1, F_RCV));
        repeat (2) @(posedge i_sys_clk);
        chk(irq, 1'b0, "tx irq masked");
        rchk(LPU_OFF_STAT, 32'h0000_0002, "tx flag held");
        $display("Test transmit done");
        rem_u.per = 32;
        rxc(cw(2'd1, F_RCV | F_DBL), 9'h096, 1'b0, 3'b001);
        wr(LPU_OFF_BAUD, 32'h0000_0000);
        tick_on <= 1'b1;
        rem_u.per = 64;
        rxc(cw(2'd1, F_RCV), 9'h03c, 1'b0, 3'b001);
        $display("Test baud source done");
        end_sim;
    end
endmodule : test_lp_uart_rx_addr_flags_baud
